/* File: verilog/usfc_top.sv */
// Serial port core: async and sync UART, master SPI, start detect, AHB-Lite registers.
// Assumes a single AHB-Lite master; pins other than the receive line are outputs.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Mode field picks async UART, sync UART, reserved or master SPI.
// - Order, phase and polarity take effect in the write that selects SPI.
// - Parity off, even or odd; appended on transmit, checked on receive.
// - Parity, stop and size settings are ignored in SPI mode.
// - Transmitter sends one or two stop bits; receiver checks only one.
// - Size code gives five to nine data bits for both directions.
// - SPI data order bit one sends LSB first, zero MSB first.
// - SPI phase chooses sampling on leading or trailing clock edge.
// - Sync UART polarity zero drives on rising, samples on falling edge.
// - SPI polarity sets clock idle level; with phase fixes timing.
// - Start detect register has no function in SPI mode.
// - Start flag sets on a start condition, clears by writing one.
// - Start interrupt needs enable, global enable and flag all set.
// - In sleep, enabled start detect with global enable wakes the processor.
// - Divisor is twelve bits: four from high byte, eight from low.
// - Low byte write reloads the prescaler at once.
// - SPI mode shares one transfer controller; parity and recovery off.
// - Map and pins are the same in UART and SPI modes; start interrupt is forced off in SPI.
// - Clocked modes run at clock over twice the sum of divisor and one.
// - Double speed cuts async oversampling from sixteen to eight.
module usfc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic receive_pin,
  output logic transmit_pin,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_n,
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  output logic start_detect_irq,
  output logic wake_request
);
  usfc_link_if lnk();
  logic dp_wr, dp_rd, rx_meta, rxd, reload_q;
  logic [5:0] dp_idx;
  logic [7:0] wd, rd8, baud_lo, frame;
  logic [3:0] baud_hi;
  logic start_detect_enable, start_detect_flag, dir, rx_en, tx_en, cs2, tx9, double_speed_bit;
  logic tx_done, hold_valid, rx_ready, parity_error_flag, frame_err;
  logic [8:0] tx_hold, rx_data, mask, rx_dat;
  logic w_data, w_lo, w_hi, w_rs, w_frame, w_ctrl, w_stat, rd_data, clr_rs;
  logic is_spi, clocked, par_en, cpha_eff, tick, tx_par, rx_perr, rx_ferr;
  logic [3:0] n, pos, rx_pos, tx_len, rx_len, tx_len_r, bit_idx, per_cnt, rx_idx;
  logic [4:0] os_n, os_last, os_cnt, rx_os;
  logic [12:0] tx_frame, tx_sh, rx_sh;
  logic xck_ph, txd, lead, trail, setup, sample, start_xfer, tx_end, rx_fin;
  usfc_pkg::usfc_tx_t tx_state;
  usfc_pkg::usfc_rx_t rx_state;

  usfc_baud_gen u_baud (.clk(clk), .nrst(nrst), .lnk(lnk));
  usfc_start_det u_det (.clk(clk), .nrst(nrst), .lnk(lnk));

  // Bus slave, zero wait states
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_idx <= 6'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite && hsize == 3'h2;
      dp_rd <= hsel && htrans[1] && !hwrite && hsize == 3'h2;
      dp_idx <= haddr[7:2];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wd = hwdata[7:0];
  assign w_data = dp_wr && dp_idx == usfc_pkg::IDX_DATA;
  assign w_lo = dp_wr && dp_idx == usfc_pkg::IDX_BAUD_LO;
  assign w_hi = dp_wr && dp_idx == usfc_pkg::IDX_BAUD_HI;
  assign w_rs = dp_wr && dp_idx == usfc_pkg::IDX_RXSTART && !is_spi;
  assign w_frame = dp_wr && dp_idx == usfc_pkg::IDX_FRAME;
  assign w_ctrl = dp_wr && dp_idx == usfc_pkg::IDX_CTRL;
  assign w_stat = dp_wr && dp_idx == usfc_pkg::IDX_STAT;
  assign rd_data = dp_rd && dp_idx == usfc_pkg::IDX_DATA;
  assign clr_rs = w_rs && wd[usfc_pkg::RS_FLAG];

  // Same map in every mode
  always_comb begin
    case (dp_idx)
      usfc_pkg::IDX_DATA: rd8 = rx_data[7:0];
      usfc_pkg::IDX_BAUD_LO: rd8 = baud_lo;
      usfc_pkg::IDX_BAUD_HI: rd8 = {4'h0, baud_hi};
      usfc_pkg::IDX_RXSTART: rd8 = {start_detect_enable, start_detect_flag, 6'h00};
      usfc_pkg::IDX_FRAME: rd8 = frame;
      usfc_pkg::IDX_CTRL: rd8 = {2'h0, dir, rx_en, tx_en, cs2, rx_data[8], tx9};
      usfc_pkg::IDX_STAT: rd8 = {rx_ready, tx_done, !hold_valid, frame_err, 1'b0, parity_error_flag,
                                 double_speed_bit, 1'b0};
      default: rd8 = 8'h00;
    endcase
  end
  assign hrdata = dp_rd ? {24'h000000, rd8} : 32'h00000000;

  // Receive pin synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_meta <= 1'b1;
      rxd <= 1'b1;
    end else begin
      rx_meta <= receive_pin;
      rxd <= rx_meta;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      baud_lo <= 8'h00;
      baud_hi <= 4'h0;
      frame <= usfc_pkg::FRAME_RST;
      start_detect_enable <= 1'b0;
      start_detect_flag <= 1'b0;
      {dir, rx_en, tx_en, cs2, tx9} <= 5'h00;
      double_speed_bit <= 1'b0;
      tx_done <= 1'b0;
      tx_hold <= 9'h000;
      hold_valid <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      if (w_lo) baud_lo <= wd;
      if (w_hi) baud_hi <= wd[3:0];
      if (w_frame) frame <= wd;
      if (w_rs) start_detect_enable <= wd[usfc_pkg::RS_EN];
      start_detect_flag <= lnk.start_seen || (start_detect_flag && !clr_rs);
      if (w_ctrl) begin
        dir <= wd[usfc_pkg::C_DIR];
        rx_en <= wd[usfc_pkg::C_RXEN];
        tx_en <= wd[usfc_pkg::C_TXEN];
        cs2 <= wd[usfc_pkg::C_CS2];
        tx9 <= wd[usfc_pkg::C_TX9];
      end
      if (w_stat) double_speed_bit <= wd[usfc_pkg::S_U2X];
      tx_done <= (tx_end && !hold_valid) || (tx_done && !(w_stat && wd[usfc_pkg::S_TXC]));
      if (w_data) begin
        tx_hold <= {tx9, wd};
        hold_valid <= 1'b1;
      end else if (start_xfer) begin
        hold_valid <= 1'b0;
      end
      reload_q <= w_lo;
    end
  end

  assign lnk.divisor = {baud_hi, baud_lo};
  assign lnk.reload = reload_q;
  assign lnk.rxd = rxd;
  assign lnk.det_en = !is_spi;
  assign tick = lnk.base_tick;

  // Mode and format decode
  assign is_spi = frame[7:6] == usfc_pkg::MODE_SPI;
  assign clocked = is_spi || frame[7:6] == usfc_pkg::MODE_SYNC;
  assign par_en = !is_spi && frame[5];
  assign cpha_eff = is_spi ? frame[usfc_pkg::F_CPHA] : 1'b1;
  assign os_n = double_speed_bit ? usfc_pkg::OS_DOUBLE : usfc_pkg::OS_NORMAL;
  assign os_last = os_n - 5'h01;

  always_comb begin
    case ({cs2, frame[2:1]})
      3'h0: n = 4'h5;
      3'h1: n = 4'h6;
      3'h2: n = 4'h7;
      3'h7: n = 4'h9;
      default: n = 4'h8;
    endcase
  end

  // Transmit frame: start, data LSB first, parity, stop bits; in SPI mode only eight data bits, in the order the order bit selects
  always_comb begin
    tx_frame = 13'h1FFF;
    pos = n + 4'h1;
    for (int i = 0; i < 9; i++) mask[i] = i < n;
    tx_par = frame[4] ^ (^(tx_hold & mask));
    tx_len = 4'h8;
    if (is_spi) begin
      for (int i = 0; i < 8; i++) tx_frame[i] = frame[usfc_pkg::F_ORDER] ? tx_hold[i] : tx_hold[7 - i];
    end else begin
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 9; i++) if (i < n) tx_frame[i + 1] = tx_hold[i];
      if (par_en) tx_frame[pos] = tx_par;
      tx_len = n + 4'h2 + {3'h0, par_en} + {3'h0, frame[3]};
    end
  end

  // Receive decode, same layout as the transmit frame
  always_comb begin
    rx_dat = 9'h000;
    rx_pos = n + 4'h1;
    rx_len = n + 4'h2 + {3'h0, par_en};
    if (is_spi) begin
      for (int i = 0; i < 8; i++) rx_dat[i] = frame[usfc_pkg::F_ORDER] ? rx_sh[i] : rx_sh[7 - i];
    end else begin
      for (int i = 0; i < 9; i++) if (i < n) rx_dat[i] = rx_sh[i + 1];
    end
    rx_perr = par_en && (rx_sh[rx_pos] != (frame[4] ^ (^rx_dat)));
    rx_ferr = !is_spi && !rx_sh[rx_pos + {3'h0, par_en}];
  end

  // Shared transfer controller
  assign start_xfer = tx_state == usfc_pkg::USFC_TX_IDLE && hold_valid && tx_en
                      && frame[7:6] != usfc_pkg::MODE_RSVD;
  assign lead = tick && clocked && tx_state == usfc_pkg::USFC_TX_RUN && !xck_ph;
  assign trail = tick && clocked && tx_state == usfc_pkg::USFC_TX_RUN && xck_ph;
  assign setup = cpha_eff ? lead : trail;
  assign sample = cpha_eff ? trail : lead;
  assign tx_end = tx_state == usfc_pkg::USFC_TX_RUN && (clocked ? (trail && per_cnt == tx_len_r - 4'h1)
                  : (tick && os_cnt == os_last && bit_idx == tx_len_r));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= usfc_pkg::USFC_TX_IDLE;
      tx_sh <= 13'h1FFF;
      tx_len_r <= 4'h0;
      bit_idx <= 4'h0;
      per_cnt <= 4'h0;
      os_cnt <= 5'h00;
      xck_ph <= 1'b0;
      txd <= 1'b1;
    end else begin
      case (tx_state)
        usfc_pkg::USFC_TX_IDLE: begin
          if (start_xfer) begin
            tx_state <= usfc_pkg::USFC_TX_RUN;
            tx_sh <= tx_frame;
            tx_len_r <= tx_len;
            per_cnt <= 4'h0;
            os_cnt <= 5'h00;
            xck_ph <= 1'b0;
            if (!cpha_eff) begin
              txd <= tx_frame[0];
              bit_idx <= 4'h1;
            end else if (!clocked) begin
              txd <= tx_frame[0];
              bit_idx <= 4'h1;
            end else begin
              bit_idx <= 4'h0;
            end
          end
        end
        usfc_pkg::USFC_TX_RUN: begin
          if (clocked) begin
            if (tick) xck_ph <= !xck_ph;
            if (setup && bit_idx < tx_len_r) begin
              txd <= tx_sh[bit_idx];
              bit_idx <= bit_idx + 4'h1;
            end
            if (trail) begin
              if (tx_end) begin
                tx_state <= usfc_pkg::USFC_TX_IDLE;
                txd <= 1'b1;
              end else begin
                per_cnt <= per_cnt + 4'h1;
              end
            end
          end else if (tick) begin
            if (os_cnt != os_last) begin
              os_cnt <= os_cnt + 5'h01;
            end else begin
              os_cnt <= 5'h00;
              if (tx_end) begin
                tx_state <= usfc_pkg::USFC_TX_IDLE;
                txd <= 1'b1;
              end else begin
                txd <= tx_sh[bit_idx];
                bit_idx <= bit_idx + 4'h1;
              end
            end
          end
        end
        default: tx_state <= usfc_pkg::USFC_TX_IDLE;
      endcase
    end
  end

  // Receiver: oversampling in async mode, clock-edge sampling in sync UART and SPI modes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= usfc_pkg::USFC_RX_IDLE;
      rx_os <= 5'h00;
      rx_idx <= 4'h0;
      rx_sh <= 13'h0000;
      rx_fin <= 1'b0;
      rx_data <= 9'h000;
      rx_ready <= 1'b0;
      parity_error_flag <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rx_fin <= 1'b0;
      if (!rx_en) begin
        rx_state <= usfc_pkg::USFC_RX_IDLE;
        rx_ready <= 1'b0;
        parity_error_flag <= 1'b0;
        frame_err <= 1'b0;
      end else begin
        if (rx_fin) begin
          rx_data <= rx_dat;
          parity_error_flag <= rx_perr;
          frame_err <= rx_ferr;
          rx_ready <= 1'b1;
        end else if (rd_data) begin
          rx_ready <= 1'b0;
        end
        if (clocked) begin
          rx_state <= usfc_pkg::USFC_RX_IDLE;
          if (start_xfer) begin
            rx_idx <= 4'h0;
          end else if (sample) begin
            rx_sh[rx_idx] <= rxd;
            rx_idx <= rx_idx + 4'h1;
          end
          if (tx_end) rx_fin <= 1'b1;
        end else begin
          case (rx_state)
            usfc_pkg::USFC_RX_IDLE: begin
              if (lnk.start_seen && frame[7:6] == usfc_pkg::MODE_ASYNC) begin
                rx_state <= usfc_pkg::USFC_RX_RUN;
                rx_os <= (os_n >> 1) - 5'h01;
                rx_idx <= 4'h0;
              end
            end
            usfc_pkg::USFC_RX_RUN: begin
              if (tick) begin
                if (rx_os != 5'h00) begin
                  rx_os <= rx_os - 5'h01;
                end else begin
                  rx_sh[rx_idx] <= rxd;
                  rx_os <= os_last;
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == 4'h0 && rxd) begin
                    rx_state <= usfc_pkg::USFC_RX_IDLE;
                  end else if (rx_idx == rx_len - 4'h1) begin
                    rx_state <= usfc_pkg::USFC_RX_IDLE;
                    rx_fin <= 1'b1;
                  end
                end
              end
            end
            default: rx_state <= usfc_pkg::USFC_RX_IDLE;
          endcase
        end
      end
    end
  end

  assign transmit_pin = txd;
  assign serial_clock_pin_o = xck_ph ^ frame[usfc_pkg::F_POL];
  assign serial_clock_pin_oe_n = !dir;
  assign start_detect_irq = start_detect_enable && global_irq_enable && start_detect_flag && !is_spi;
  assign wake_request = start_detect_irq && sleep_active;

  property p_rs_set;
    @(posedge clk) disable iff (!nrst) lnk.start_seen |=> start_detect_flag;
  endproperty
  a_rs_set: assert property (p_rs_set) else $error("start flag not set");

  property p_rs_hold;
    @(posedge clk) disable iff (!nrst) (start_detect_flag && !clr_rs) |=> start_detect_flag;
  endproperty
  a_rs_hold: assert property (p_rs_hold) else $error("start flag lost");

  property p_irq;
    @(posedge clk) disable iff (!nrst)
      ($rose(start_detect_flag) && start_detect_enable && global_irq_enable) |-> start_detect_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("start interrupt missing");

  property p_spi_quiet;
    @(posedge clk) disable iff (!nrst) is_spi |-> (!start_detect_irq && !wake_request) ##1 $stable(start_detect_flag);
  endproperty
  a_spi_quiet: assert property (p_spi_quiet) else $error("start logic active in spi");

  property p_spi_nopar;
    @(posedge clk) disable iff (!nrst) (rx_fin && is_spi && rx_en) |=> !parity_error_flag;
  endproperty
  a_spi_nopar: assert property (p_spi_nopar) else $error("parity error in spi");

  property p_perr;
    @(posedge clk) disable iff (!nrst) (rx_fin && rx_perr && rx_en) |=> parity_error_flag;
  endproperty
  a_perr: assert property (p_perr) else $error("parity mismatch not flagged");

  property p_xck;
    @(posedge clk) disable iff (!nrst) (lead && !tx_end) |=> (xck_ph && serial_clock_pin_o != frame[0]);
  endproperty
  a_xck: assert property (p_xck) else $error("serial clock did not toggle");

  property p_async_clk;
    @(posedge clk) disable iff (!nrst) (frame[7:6] == usfc_pkg::MODE_ASYNC) |=> !xck_ph || $past(clocked);
  endproperty
  a_async_clk: assert property (p_async_clk) else $error("clock runs in async mode");

  property p_lsb;
    @(posedge clk) disable iff (!nrst)
      (start_xfer && is_spi && frame[usfc_pkg::F_ORDER] && !frame[usfc_pkg::F_CPHA]) |=> txd == $past(tx_hold[0]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("spi lsb not first");

  property p_two_stop;
    @(posedge clk) disable iff (!nrst) (start_xfer && !clocked && frame[3])
      |-> (tx_frame[tx_len - 4'h1] && tx_frame[tx_len - 4'h2] && tx_len == n + 4'h3 + {3'h0, par_en});
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("two stop bits not framed");
endmodule
`default_nettype wire

/* File: common/usfc_pkg.sv */
// Register map, field positions, mode codes and state types of the serial port.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
package usfc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_DATA = 6'h08;
  localparam logic [5:0] IDX_BAUD_LO = 6'h09;
  localparam logic [5:0] IDX_BAUD_HI = 6'h0A;
  localparam logic [5:0] IDX_RXSTART = 6'h0B;
  localparam logic [5:0] IDX_FRAME = 6'h0C;
  localparam logic [5:0] IDX_CTRL = 6'h0D;
  localparam logic [5:0] IDX_STAT = 6'h0E;
  localparam logic [7:0] FRAME_RST = 8'h06;
  localparam int BAUD_W = 12;
  // Frame format fields
  localparam int F_ORDER = 2;
  localparam int F_CPHA = 1;
  localparam int F_POL = 0;
  localparam logic [1:0] MODE_ASYNC = 2'b00;
  localparam logic [1:0] MODE_SYNC = 2'b01;
  localparam logic [1:0] MODE_RSVD = 2'b10;
  localparam logic [1:0] MODE_SPI = 2'b11;
  // Start detect control fields
  localparam int RS_EN = 7;
  localparam int RS_FLAG = 6;
  // Control fields
  localparam int C_DIR = 5;
  localparam int C_RXEN = 4;
  localparam int C_TXEN = 3;
  localparam int C_CS2 = 2;
  localparam int C_TX9 = 0;
  // Status fields
  localparam int S_TXC = 6;
  localparam int S_U2X = 1;
  // Oversampling per bit in asynchronous mode
  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;
  typedef enum logic {USFC_TX_IDLE, USFC_TX_RUN} usfc_tx_t;
  typedef enum logic {USFC_RX_IDLE, USFC_RX_RUN} usfc_rx_t;
endpackage

/* File: common/usfc_link_if.sv */
// Signals between the port core, the baud generator and the start detector.
// Assumes all three run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface usfc_link_if;
  logic [11:0] divisor;
  logic reload;
  logic base_tick;
  logic rxd;
  logic det_en;
  logic start_seen;
  modport gen(input divisor, input reload, output base_tick);
  modport det(input rxd, input det_en, output start_seen);
  modport core(output divisor, output reload, output rxd, output det_en, input base_tick, input start_seen);
endinterface
`default_nettype wire

/* File: verilog/usfc_baud_gen.sv */
// Baud prescaler: one base tick every divisor plus one clocks.
// Assumes reload is a one-cycle pulse after a low byte write.
`timescale 1ns/100ps
`default_nettype none
module usfc_baud_gen (
  input wire logic clk,
  input wire logic nrst,
  usfc_link_if.gen lnk
);
  logic [11:0] count;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 12'h000;
    end else if (lnk.reload || count == 12'h000) begin
      count <= lnk.divisor;
    end else begin
      count <= count - 12'h001;
    end
  end

  assign lnk.base_tick = (count == 12'h000) && !lnk.reload;

  property p_reload;
    @(posedge clk) disable iff (!nrst) lnk.reload |=> (count == $past(lnk.divisor));
  endproperty
  a_reload: assert property (p_reload) else $error("prescaler not reloaded");
endmodule
`default_nettype wire

/* File: verilog/usfc_start_det.sv */
// Start condition detector on the synchronised receive line.
// Assumes rxd has already passed two flip-flops.
`timescale 1ns/100ps
`default_nettype none
module usfc_start_det (
  input wire logic clk,
  input wire logic nrst,
  usfc_link_if.det lnk
);
  logic prev;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b1;
    end else begin
      prev <= lnk.rxd;
    end
  end

  // Falling edge of an idle-high line
  assign lnk.start_seen = lnk.det_en && prev && !lnk.rxd;

  property p_gate;
    @(posedge clk) disable iff (!nrst) lnk.start_seen |-> (lnk.det_en && $past(lnk.rxd) && !lnk.rxd);
  endproperty
  a_gate: assert property (p_gate) else $error("start seen while detector off");
endmodule
`default_nettype wire

/* File: test/usfc_peer.sv */
// Remote serial peer: frame decoder on the transmit line, driver of the receive line.
// Assumes the bench gives the bit time in clocks; lines idle high.
`timescale 1ns/100ps
`default_nettype none
module usfc_peer (
  input wire logic clk,
  input wire logic txd,
  input wire logic loop_en,
  input wire logic [15:0] bit_cyc,
  output logic rxd,
  output var logic [8:0] word,
  output var int n_frames
);
  // Echo while enabled, else the line rests at its idle level
  assign rxd = loop_en ? txd : 1'b1;
  // Samples nine bit times after a start edge, mid-bit
  initial begin
    word = '0;
    n_frames = 0;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_cyc) @(posedge clk);
        word[i] = txd;
      end
      n_frames++;
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_usfc_top.sv */
// Testbench of the serial port: register bus, async frames, start detect, clocked modes.
// Assumes the peer model echoes the transmit line back into the receiver.
`timescale 1ns/100ps
`default_nettype none
module tb_usfc_top;
  logic clk, nrst, hsel, hwrite, loop_en, gie, slp, hreadyout, hresp, rxd, txd, sck, sck_oe_n, irq, wake;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [8:0] word;
  logic [15:0] bit_cyc;
  logic [7:0] q;
  int n_frames, mismatches, n_checks, n;
  localparam logic [7:0] fr [7] = '{8'h06, 8'h00, 8'h02, 8'h04, 8'h24, 8'h34, 8'h06};
  localparam logic [7:0] dt [7] = '{8'hA5, 8'h15, 8'h2A, 8'h55, 8'h07, 8'h07, 8'h00};
  localparam logic [8:0] ex [7] = '{9'h1A5, 9'h1F5, 9'h1EA, 9'h1D5, 9'h187, 9'h107, 9'h100};
  localparam logic [7:0] sf [2] = '{8'hC5, 8'hC2};
  usfc_top usfc_top_i (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .receive_pin(rxd), .transmit_pin(txd), .serial_clock_pin_o(sck), .serial_clock_pin_oe_n(sck_oe_n),
    .global_irq_enable(gie), .sleep_active(slp), .start_detect_irq(irq), .wake_request(wake));
  usfc_peer usfc_peer_i (.clk(clk), .txd(txd), .loop_en(loop_en), .bit_cyc(bit_cyc), .rxd(rxd), .word(word),
    .n_frames(n_frames));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Single word transfer; read data is taken at the data phase edge
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, output logic [7:0] r);
    hsel <= 1'b1;
    haddr <= {24'h000000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, idx, 8'h00, r);
    chk(nm, {24'h0, r}, {24'h0, e});
  endtask
  task automatic send(input logic [7:0] d, input logic [8:0] e);
    int k;
    k = n_frames;
    wr(usfc_pkg::IDX_DATA, d);
    for (int i = 0; i < 20000 && n_frames == k; i++) @(posedge clk);
    chk("frame_seen", n_frames, k + 1);
    chk("frame", {23'h0, word}, {23'h0, e});
    repeat (3 * bit_cyc) @(posedge clk);
  endtask
  // Cycles between two rising edges of the serial clock
  task automatic meas(output int p);
    p = 0;
    do @(posedge clk); while (sck !== 1'b0);
    do @(posedge clk); while (sck !== 1'b1);
    do begin
      @(posedge clk);
      p++;
    end while (sck !== 1'b0);
    do begin
      @(posedge clk);
      p++;
    end while (sck !== 1'b1);
  endtask
  task automatic t_reset();
    rdc("frame_rst", usfc_pkg::IDX_FRAME, 8'h06);
    rdc("baud_lo_rst", usfc_pkg::IDX_BAUD_LO, 8'h00);
    rdc("baud_hi_rst", usfc_pkg::IDX_BAUD_HI, 8'h00);
    rdc("rxstart_rst", usfc_pkg::IDX_RXSTART, 8'h00);
    rdc("unmapped", 6'h3F, 8'h00);
    rdc("stat_rst", usfc_pkg::IDX_STAT, 8'h20);
    chk("okay", hresp, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_async();
    loop_en <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(usfc_pkg::IDX_FRAME, fr[i]);
      wr(usfc_pkg::IDX_CTRL, i == 6 ? 8'h1D : 8'h18);
      send(dt[i], ex[i]);
      rdc("rx_data", usfc_pkg::IDX_DATA, dt[i]);
      xfer(1'b0, usfc_pkg::IDX_STAT, 8'h00, q);
      chk("parity_err", q[2], 1'b0);
    end
    wr(usfc_pkg::IDX_CTRL, 8'h18);
    // Two stop bits: frame of eleven bit times ends after 176 clocks
    wr(usfc_pkg::IDX_STAT, 8'h40);
    wr(usfc_pkg::IDX_FRAME, 8'h0E);
    wr(usfc_pkg::IDX_DATA, 8'hFF);
    repeat (164) @(posedge clk);
    xfer(1'b0, usfc_pkg::IDX_STAT, 8'h00, q);
    chk("txc_stop1", q[6], 1'b0);
    repeat (16) @(posedge clk);
    xfer(1'b0, usfc_pkg::IDX_STAT, 8'h00, q);
    chk("txc_stop2", q[6], 1'b1);
    rdc("start_flag", usfc_pkg::IDX_RXSTART, 8'h40);
    wr(usfc_pkg::IDX_RXSTART, 8'h80);
    gie <= 1'b1;
    @(posedge clk);
    chk("irq_on", irq, 1'b1);
    chk("wake_awake", wake, 1'b0);
    slp <= 1'b1;
    @(posedge clk);
    chk("wake_on", wake, 1'b1);
    gie <= 1'b0;
    @(posedge clk);
    chk("irq_gie_off", irq, 1'b0);
    chk("wake_gie_off", wake, 1'b0);
    gie <= 1'b1;
    slp <= 1'b0;
    wr(usfc_pkg::IDX_RXSTART, 8'hC0);
    rdc("flag_clear", usfc_pkg::IDX_RXSTART, 8'h80);
    chk("irq_clear", irq, 1'b0);
    wr(usfc_pkg::IDX_STAT, 8'h02);
    bit_cyc <= 16'd8;
    send(8'h3C, 9'h13C);
    wr(usfc_pkg::IDX_STAT, 8'h00);
    $display("test async done");
  endtask
  task automatic t_clocked();
    wr(usfc_pkg::IDX_FRAME, 8'h46);
    wr(usfc_pkg::IDX_BAUD_LO, 8'h02);
    wr(usfc_pkg::IDX_DATA, 8'h5A);
    meas(n);
    chk("sck_period_lo", n, 6);
    repeat (100) @(posedge clk);
    wr(usfc_pkg::IDX_BAUD_HI, 8'h01);
    wr(usfc_pkg::IDX_BAUD_LO, 8'h02);
    wr(usfc_pkg::IDX_DATA, 8'h5A);
    meas(n);
    chk("sck_period_hi", n, 518);
    repeat (6000) @(posedge clk);
    wr(usfc_pkg::IDX_RXSTART, 8'h80);
    $display("test clocked done");
  endtask
  task automatic t_spi();
    logic [7:0] v;
    logic tgt;
    wr(usfc_pkg::IDX_BAUD_HI, 8'h00);
    wr(usfc_pkg::IDX_BAUD_LO, 8'h00);
    wr(usfc_pkg::IDX_CTRL, 8'h38);
    @(posedge clk);
    chk("sck_drive", sck_oe_n, 1'b0);
    for (int m = 0; m < 2; m++) begin
      wr(usfc_pkg::IDX_FRAME, sf[m]);
      @(posedge clk);
      chk("sck_idle", sck, sf[m][0]);
      tgt = sf[m][1] ? sf[m][0] : ~sf[m][0];
      // Half period of eight clocks covers the two-flop delay of the echoed line
      wr(usfc_pkg::IDX_BAUD_LO, 8'h07);
      wr(usfc_pkg::IDX_DATA, 8'h4D);
      for (int b = 0; b < 8; b++) begin
        do @(posedge clk); while (sck !== ~tgt);
        do @(posedge clk); while (sck !== tgt);
        v[b] = txd;
      end
      chk("spi_bits", v, m == 0 ? 8'h4D : 8'hB2);
      repeat (20) @(posedge clk);
      rdc("spi_rx", usfc_pkg::IDX_DATA, 8'h4D);
    end
    gie <= 1'b1;
    @(posedge clk);
    chk("irq_spi", irq, 1'b0);
    wr(usfc_pkg::IDX_RXSTART, 8'h40);
    rdc("rs_spi", usfc_pkg::IDX_RXSTART, 8'hC0);
    $display("test spi done");
  endtask
  initial begin
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    loop_en = 1'b0;
    gie = 1'b0;
    slp = 1'b0;
    bit_cyc = 16'd16;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_async();
    t_clocked();
    t_spi();
    print_verdict();
  end
  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
